/* rtl/lnbp_ctrl.sv */
// lnbp_ctrl: overcurrent shutdown, 25% limit raise, in-rush window, pulse skip, cable-open flag, tone control
// assumes analog comparators and the tone gate pin arrive synchronous to the 20 MHz clock
// Contract
// - Current held at limit beyond 45 ms switches the LNB output off.
// - The overcurrent fault flag is set in the same cycle the output turns off.
// - With boost enabled, a limit event raises the limit 25% for a quarter disable time.
// - After the boost the limit returns and the boost enable bit clears itself.
// - With boost enable clear, a short is clamped at the programmed limit only.
// - Start-up or reconfiguration surge is allowed up to the limit for at most 45 ms.
// - Boost node above 28 V enters pulse skipping, leaving with 350 mV hysteresis.
// - Boost node above 23.7 V at no load sets the cable-open flag.
// - Tone select zero: internal 22 kHz tone only while the tone gate is high.
// - Tone select one: the tone gate square wave is copied to the output.
// - External mode returns to dc once the gate stays low beyond 42 us.
// - Pull-down is about 30 mA with tone gate low and 60 mA when high.
`default_nettype none
module lnbp_ctrl #(
    parameter int OC_DISABLE_CYCLES = lnbp_pkg::OC_DISABLE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [lnbp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lnbp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [lnbp_pkg::DATA_W-1:0] reg_rdata,
    // analog comparators
    input wire logic current_at_limit,
    input wire logic boost_above_skip,
    input wire logic boost_above_return,
    input wire logic boost_above_cable_open,
    input wire logic output_reconfig,
    // tone pin
    input wire logic tone_gate_input,
    // analog controls
    output logic lnb_output_enable,
    output logic limit_raise,
    output logic inrush_allow,
    output logic pulse_skip,
    output logic sink_current_disable,
    output logic tone_active,
    output logic tone_level,
    output logic pulldown_strong,
    // interrupt
    output logic irq
);
    localparam int CNT_W = lnbp_pkg::CNT_W;
    localparam logic [CNT_W-1:0] OC_LIMIT = CNT_W'(OC_DISABLE_CYCLES);
    localparam logic [CNT_W-1:0] BOOST_LIMIT = CNT_W'(OC_DISABLE_CYCLES / lnbp_pkg::BOOST_DIVISOR);
    localparam logic [CNT_W-1:0] TONE_LIMIT = CNT_W'(lnbp_pkg::TONE_HALF_CYCLES);
    localparam logic [CNT_W-1:0] IDLE_LIMIT = CNT_W'(lnbp_pkg::EXT_TONE_IDLE_CYCLES);

    // protection state
    logic [lnbp_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic ocp_r, ocp_nxt;
    logic boost_active_r, boost_active_nxt;
    logic limit_d_r, limit_d_nxt;
    logic inrush_r, inrush_nxt;
    logic inrush_spent_r, inrush_spent_nxt;
    // monitor state
    logic skip_r, skip_nxt;
    logic cable_r, cable_nxt;
    // tone state
    logic tone_level_r, tone_level_nxt;
    logic tone_active_r, tone_active_nxt;
    logic pulldown_r, pulldown_nxt;
    // bus and interrupt state
    logic [lnbp_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [lnbp_pkg::IRQ_W-1:0] irq_en_r, irq_en_nxt;
    logic [lnbp_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;

    // timers
    logic [CNT_W-1:0] oc_count, boost_count, inrush_count, idle_count;
    logic oc_done, boost_done, inrush_done, tone_done, idle_done;
    logic oc_run, tone_run, idle_run;

    // decoded strobes and events
    logic wr_ctrl, wr_irq_en, wr_irq_clr;
    logic limit_event, boost_start, host_sets_boost, host_enables;
    logic ext_mode;
    logic [lnbp_pkg::IRQ_W-1:0] irq_events;
    logic [lnbp_pkg::DATA_W-1:0] status_word;

    assign wr_ctrl = reg_write && (reg_addr == lnbp_pkg::ADDR_CTRL);
    assign wr_irq_en = reg_write && (reg_addr == lnbp_pkg::ADDR_IRQ_ENABLE);
    assign wr_irq_clr = reg_write && (reg_addr == lnbp_pkg::ADDR_IRQ_CLEAR);
    assign host_sets_boost = wr_ctrl && reg_wdata[lnbp_pkg::CTRL_BOOST_EN];
    assign host_enables = wr_ctrl && reg_wdata[lnbp_pkg::CTRL_OUT_EN];
    assign ext_mode = ctrl_r[lnbp_pkg::CTRL_TONE_SRC];

    // only a continuous stretch at the limit reaches the end of the count
    assign oc_run = current_at_limit && ctrl_r[lnbp_pkg::CTRL_OUT_EN];
    assign tone_run = !ext_mode && tone_gate_input;
    assign idle_run = ext_mode && !tone_gate_input && tone_active_r;

    lnbp_timer #(.WIDTH(CNT_W)) u_oc_timer (
        .clock(clock), .nrst(nrst), .run(oc_run), .limit(OC_LIMIT), .count(oc_count), .done(oc_done)
    );
    lnbp_timer #(.WIDTH(CNT_W)) u_boost_timer (
        .clock(clock), .nrst(nrst), .run(boost_active_r), .limit(BOOST_LIMIT), .count(boost_count),
        .done(boost_done)
    );
    lnbp_timer #(.WIDTH(CNT_W)) u_inrush_timer (
        .clock(clock), .nrst(nrst), .run(inrush_r), .limit(OC_LIMIT), .count(inrush_count),
        .done(inrush_done)
    );
    lnbp_timer #(.WIDTH(CNT_W)) u_tone_timer (
        .clock(clock), .nrst(nrst), .run(tone_run), .limit(TONE_LIMIT), .count(), .done(tone_done)
    );
    lnbp_timer #(.WIDTH(CNT_W)) u_idle_timer (
        .clock(clock), .nrst(nrst), .run(idle_run), .limit(IDLE_LIMIT), .count(idle_count), .done(idle_done)
    );

    // protection: overcurrent shutdown, limit raise, in-rush window
    always_comb begin
        limit_event = current_at_limit && !limit_d_r;
        boost_start = ctrl_r[lnbp_pkg::CTRL_BOOST_EN] && limit_event && !boost_active_r
                      && ctrl_r[lnbp_pkg::CTRL_OUT_EN];
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = reg_wdata[lnbp_pkg::CTRL_W-1:0];
        end
        // a host write setting the bit in the same cycle keeps the request
        if (boost_done && !host_sets_boost) begin
            ctrl_nxt[lnbp_pkg::CTRL_BOOST_EN] = 1'b0;
        end
        // shutdown beats a simultaneous host enable; no automatic restart
        if (oc_done) begin
            ctrl_nxt[lnbp_pkg::CTRL_OUT_EN] = 1'b0;
        end
        ocp_nxt = oc_done || (ocp_r && !host_enables);
        // without a start the limit stays at the programmed value
        boost_active_nxt = boost_start
                           || (boost_active_r && !boost_done && !oc_done
                               && ctrl_r[lnbp_pkg::CTRL_OUT_EN]);
        limit_d_nxt = current_at_limit;
        inrush_nxt = ctrl_r[lnbp_pkg::CTRL_OUT_EN] && output_reconfig && !inrush_spent_r && !inrush_done;
        inrush_spent_nxt = output_reconfig && (inrush_spent_r || inrush_done);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= lnbp_pkg::CTRL_RESET;
            ocp_r <= 1'b0;
            boost_active_r <= 1'b0;
            limit_d_r <= 1'b0;
            inrush_r <= 1'b0;
            inrush_spent_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ocp_r <= ocp_nxt;
            boost_active_r <= boost_active_nxt;
            limit_d_r <= limit_d_nxt;
            inrush_r <= inrush_nxt;
            inrush_spent_r <= inrush_spent_nxt;
        end
    end

    // boost node monitors
    always_comb begin
        skip_nxt = skip_r;
        if (boost_above_skip) begin
            skip_nxt = 1'b1;
        end else if (!boost_above_return) begin
            skip_nxt = 1'b0;
        end
        // live flag; the sticky copy lives in the interrupt status
        cable_nxt = boost_above_cable_open;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            skip_r <= 1'b0;
            cable_r <= 1'b0;
        end else begin
            skip_r <= skip_nxt;
            cable_r <= cable_nxt;
        end
    end

    // tone generation
    always_comb begin
        if (ext_mode) begin
            tone_level_nxt = tone_gate_input;
            tone_active_nxt = tone_gate_input || (tone_active_r && !idle_done);
        end else begin
            tone_active_nxt = tone_gate_input;
            tone_level_nxt = 1'b0;
            if (tone_gate_input) begin
                tone_level_nxt = tone_done ? !tone_level_r : tone_level_r;
            end
        end
        pulldown_nxt = tone_gate_input;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tone_level_r <= 1'b0;
            tone_active_r <= 1'b0;
            pulldown_r <= 1'b0;
        end else begin
            tone_level_r <= tone_level_nxt;
            tone_active_r <= tone_active_nxt;
            pulldown_r <= pulldown_nxt;
        end
    end

    // register reads, interrupt status and line
    always_comb begin
        status_word = '0;
        status_word[lnbp_pkg::ST_OCP] = ocp_r;
        status_word[lnbp_pkg::ST_CABLE] = cable_r;
        status_word[lnbp_pkg::ST_SKIP] = skip_r;
        status_word[lnbp_pkg::ST_BOOST] = boost_active_r;
        status_word[lnbp_pkg::ST_INRUSH] = inrush_r;
        status_word[lnbp_pkg::ST_TONE] = tone_active_r;
        irq_events = '0;
        irq_events[lnbp_pkg::IRQ_OCP] = oc_done;
        irq_events[lnbp_pkg::IRQ_CABLE] = boost_above_cable_open && !cable_r;
        irq_events[lnbp_pkg::IRQ_BOOST_END] = boost_done;
        // a new event in the clearing cycle survives
        irq_stat_nxt = irq_stat_r | irq_events;
        if (wr_irq_clr) begin
            irq_stat_nxt = (irq_stat_r & ~reg_wdata[lnbp_pkg::IRQ_W-1:0]) | irq_events;
        end
        irq_en_nxt = wr_irq_en ? reg_wdata[lnbp_pkg::IRQ_W-1:0] : irq_en_r;
        irq_nxt = |(irq_stat_nxt & irq_en_nxt);
        rdata_nxt = '0;
        if (reg_read) begin
            unique case (reg_addr)
                lnbp_pkg::ADDR_CTRL: rdata_nxt = {4'h0, ctrl_r};
                lnbp_pkg::ADDR_STATUS: rdata_nxt = status_word;
                lnbp_pkg::ADDR_IRQ_STATUS: rdata_nxt = {5'h00, irq_stat_r};
                lnbp_pkg::ADDR_IRQ_ENABLE: rdata_nxt = {5'h00, irq_en_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= lnbp_pkg::IRQ_RESET;
            irq_en_r <= lnbp_pkg::IRQ_RESET;
            rdata_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign lnb_output_enable = ctrl_r[lnbp_pkg::CTRL_OUT_EN];
    assign sink_current_disable = ctrl_r[lnbp_pkg::CTRL_SINK_CURRENT_DISABLE];
    assign limit_raise = boost_active_r;
    assign inrush_allow = inrush_r;
    assign pulse_skip = skip_r;
    assign tone_active = tone_active_r;
    assign tone_level = tone_level_r;
    assign pulldown_strong = pulldown_r;
    assign irq = irq_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_boost_raised;
        boost_active_r && limit_raise;
    endsequence
    sequence s_boost_dropped;
        !boost_active_r && !ctrl_r[lnbp_pkg::CTRL_BOOST_EN];
    endsequence

    property p_oc_shutdown;
        oc_done |=> !lnb_output_enable;
    endproperty
    a_oc_shutdown: assert property (p_oc_shutdown) else $error("output stayed on after disable time");

    property p_oc_count_value;
        oc_done |-> oc_count == OC_LIMIT - 1'b1;
    endproperty
    a_oc_count_value: assert property (p_oc_count_value) else $error("shutdown at wrong count");

    property p_fault_with_off;
        $fell(lnb_output_enable) && !$past(wr_ctrl) |-> $rose(ocp_r);
    endproperty
    a_fault_with_off: assert property (p_fault_with_off) else $error("fault flag not set with shutdown");

    property p_no_restart;
        !lnb_output_enable && !wr_ctrl |=> !lnb_output_enable;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("output restarted without host");

    property p_boost_start;
        boost_start |=> s_boost_raised ##1 boost_count == 1;
    endproperty
    a_boost_start: assert property (p_boost_start) else $error("limit raise did not start");

    property p_boost_end;
        boost_done && !wr_ctrl && !oc_done |-> boost_count == BOOST_LIMIT - 1'b1 ##1 s_boost_dropped;
    endproperty
    a_boost_end: assert property (p_boost_end) else $error("raise did not end after quarter time");

    property p_no_boost;
        !ctrl_r[lnbp_pkg::CTRL_BOOST_EN] && !boost_active_r |=> !limit_raise;
    endproperty
    a_no_boost: assert property (p_no_boost) else $error("limit raised with boost disabled");

    property p_inrush_max;
        inrush_allow && inrush_count == OC_LIMIT - 1'b1 |=> !inrush_allow;
    endproperty
    a_inrush_max: assert property (p_inrush_max) else $error("surge window too long");

    property p_skip;
        (boost_above_skip |=> pulse_skip) and (!boost_above_skip && !boost_above_return |=> !pulse_skip);
    endproperty
    a_skip: assert property (p_skip) else $error("pulse skip hysteresis wrong");

    property p_cable;
        // the sticky bit is only owed at the rise; the host may clear it while the level stays
        (boost_above_cable_open |=> status_word[lnbp_pkg::ST_CABLE])
        and (boost_above_cable_open && !cable_r |=> irq_stat_r[lnbp_pkg::IRQ_CABLE]);
    endproperty
    a_cable: assert property (p_cable) else $error("cable open not flagged");

    property p_int_tone_gate;
        !ext_mode && !tone_gate_input |=> !tone_level && !tone_active;
    endproperty
    a_int_tone_gate: assert property (p_int_tone_gate) else $error("internal tone without gate");

    property p_int_tone_period;
        !ext_mode && tone_gate_input && tone_done |=> $changed(tone_level);
    endproperty
    a_int_tone_period: assert property (p_int_tone_period) else $error("internal tone half period wrong");

    property p_ext_copy;
        ext_mode && !wr_ctrl |=> tone_level == $past(tone_gate_input);
    endproperty
    a_ext_copy: assert property (p_ext_copy) else $error("external tone not copied");

    property p_ext_idle;
        $past(ext_mode) && $fell(tone_active) |-> $past(idle_count) == IDLE_LIMIT - 1'b1;
    endproperty
    a_ext_idle: assert property (p_ext_idle) else $error("dc return at wrong time");

    property p_pulldown;
        1'b1 |=> pulldown_strong == $past(tone_gate_input);
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down strength wrong");

    property p_oc_restart;
        !current_at_limit |=> oc_count == '0;
    endproperty
    a_oc_restart: assert property (p_oc_restart) else $error("overcurrent timer not restarted");
endmodule // lnbp_ctrl
`default_nettype wire

/* rtl/lnbp_pkg.sv */
// lnbp_pkg: constants shared by the LNB output protection and tone control block
// assumes a 20 MHz clock; all timing counts are derived here from the printed times
`default_nettype none
package lnbp_pkg;
    // clock
    localparam int CLOCK_HZ = 20_000_000;
    localparam int CLOCK_PERIOD_NS = 50;
    // overcurrent disable time and derived counts
    localparam int OC_DISABLE_TIME_MS = 45;
    localparam int OC_DISABLE_CYCLES = OC_DISABLE_TIME_MS * (CLOCK_HZ / 1000);
    localparam int BOOST_DIVISOR = 4;
    // internal tone, half period in cycles (rounded down)
    localparam int TONE_FREQ_HZ = 22_000;
    localparam int TONE_HALF_CYCLES = CLOCK_HZ / (2 * TONE_FREQ_HZ);
    // external tone idle time before return to the dc level (rounded up)
    localparam int EXT_TONE_IDLE_TIME_NS = 42_000;
    localparam int EXT_TONE_IDLE_CYCLES = (EXT_TONE_IDLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // timer width, enough for the overcurrent count
    localparam int CNT_W = 20;
    // register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 3'h4;
    // control register fields
    localparam int CTRL_W = 4;
    localparam int CTRL_OUT_EN = 0;
    localparam int CTRL_BOOST_EN = 1;
    localparam int CTRL_SINK_CURRENT_DISABLE = 2;
    localparam int CTRL_TONE_SRC = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
    // status register fields
    localparam int ST_OCP = 0;
    localparam int ST_CABLE = 1;
    localparam int ST_SKIP = 2;
    localparam int ST_BOOST = 3;
    localparam int ST_INRUSH = 4;
    localparam int ST_TONE = 5;
    // interrupt fields
    localparam int IRQ_W = 3;
    localparam int IRQ_OCP = 0;
    localparam int IRQ_CABLE = 1;
    localparam int IRQ_BOOST_END = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
endpackage
`default_nettype wire

/* rtl/lnbp_timer.sv */
// lnbp_timer: cycle counter that runs while enabled and flags its last cycle
// assumes limit is at least one and stays steady while the counter runs
`default_nettype none
module lnbp_timer #(
    parameter int WIDTH = 20
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic [WIDTH-1:0] limit,
    // state
    output logic [WIDTH-1:0] count,
    output logic done
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    always_comb begin
        done = run && (count_r == limit - 1'b1);
        count_nxt = '0;
        // dropping run restarts from zero
        if (run && !done) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
endmodule // lnbp_timer
`default_nettype wire

/* sim/lnbp_lnb_model.sv */
// lnbp_lnb_model: load on the coax as seen by the block's comparators
// assumes the bench sets a short and a boost-node target; boost node slews 50 mV per clock
`default_nettype none
module lnbp_lnb_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // device side
    input wire logic lnb_output_enable,
    // scenario controls
    input wire logic shorted,
    input wire logic [15:0] target_mv,
    // comparator view
    output logic current_at_limit,
    output logic boost_above_skip,
    output logic boost_above_return,
    output logic boost_above_cable_open
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] boost_mv_r;
    logic [15:0] boost_mv_nxt;
    // a short draws limit current only while the output is on
    assign current_at_limit = shorted & lnb_output_enable;
    // thresholds 28 V, 28 V less 350 mV, 23.7 V
    assign boost_above_skip = boost_mv_r > 16'h6d60;
    assign boost_above_return = boost_mv_r > 16'h6c02;
    assign boost_above_cable_open = boost_mv_r > 16'h5c94;
    always_comb begin
        if (boost_mv_r + 16'h0032 <= target_mv) begin
            boost_mv_nxt = boost_mv_r + 16'h0032;
        end else if (boost_mv_r >= target_mv + 16'h0032) begin
            boost_mv_nxt = boost_mv_r - 16'h0032;
        end else begin
            boost_mv_nxt = target_mv;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            boost_mv_r <= 16'h0000;
        end else begin
            boost_mv_r <= boost_mv_nxt;
        end
    end
endmodule // lnbp_lnb_model
`default_nettype wire

/* sim/lnbp_ctrl_tb.sv */
// lnbp_ctrl_tb: host-side register tests of protection and tone control
// assumes lnbp_lnb_model drives the comparators; a short disable count keeps the run brief
`default_nettype none
module lnbp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OC = 64;
    logic clock, nrst, reg_write, reg_read, output_reconfig, tone_gate_input, shorted;
    logic [lnbp_pkg::ADDR_W-1:0] reg_addr;
    logic [lnbp_pkg::DATA_W-1:0] reg_wdata, reg_rdata;
    logic current_at_limit, boost_above_skip, boost_above_return, boost_above_cable_open;
    logic lnb_output_enable, limit_raise, inrush_allow, pulse_skip, sink_current_disable;
    logic tone_active, tone_level, pulldown_strong, irq, g, lv, seen;
    logic [15:0] target_mv;
    int fails, n_compared, n, m, bad;
    lnbp_ctrl #(.OC_DISABLE_CYCLES(OC)) dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .current_at_limit(current_at_limit), .boost_above_skip(boost_above_skip),
        .boost_above_return(boost_above_return), .boost_above_cable_open(boost_above_cable_open),
        .output_reconfig(output_reconfig), .tone_gate_input(tone_gate_input),
        .lnb_output_enable(lnb_output_enable), .limit_raise(limit_raise), .inrush_allow(inrush_allow),
        .pulse_skip(pulse_skip), .sink_current_disable(sink_current_disable), .tone_active(tone_active),
        .tone_level(tone_level), .pulldown_strong(pulldown_strong), .irq(irq));
    lnbp_lnb_model lnb (.clock(clock), .nrst(nrst), .lnb_output_enable(lnb_output_enable),
        .shorted(shorted), .target_mv(target_mv), .current_at_limit(current_at_limit),
        .boost_above_skip(boost_above_skip), .boost_above_return(boost_above_return),
        .boost_above_cable_open(boost_above_cable_open));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic final_report();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [lnbp_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [lnbp_pkg::ADDR_W-1:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk8(reg_rdata, exp, what);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic drive(input logic s, input logic [15:0] t);
        @(posedge clock);
        shorted <= s;
        target_mv <= t;
    endtask
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        final_report();
    end
    initial begin
        nrst = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        output_reconfig = 1'b0;
        tone_gate_input = 1'b0;
        shorted = 1'b0;
        target_mv = 16'h0000;
        fails = 0;
        n_compared = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rdchk(lnbp_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        rdchk(lnbp_pkg::ADDR_STATUS, 8'h00, "status reset");
        wr(3'h5, 8'hff);
        rdchk(3'h5, 8'h00, "unmapped");
        wr(lnbp_pkg::ADDR_CTRL, 8'h01);
        @(posedge clock);
        output_reconfig <= 1'b1;
        cyc(4);
        chk1(inrush_allow, 1'b1, "surge window open");
        cyc(OC);
        chk1(inrush_allow, 1'b0, "surge window capped");
        @(posedge clock);
        output_reconfig <= 1'b0;
        // broken overcurrent must never add up to a shutdown
        repeat (2) begin
            drive(1'b1, 16'h0000);
            cyc(OC - 8);
            drive(1'b0, 16'h0000);
            cyc(2);
        end
        chk1(lnb_output_enable, 1'b1, "timer restart");
        drive(1'b1, 16'h0000);
        n = 0;
        while (lnb_output_enable === 1'b1 && n < 200) begin
            @(posedge clock);
            #1 n++;
        end
        chk1(n >= OC && n <= OC + 1, 1'b1, "shutdown time");
        rdchk(lnbp_pkg::ADDR_STATUS, 8'h01, "fault flag");
        rdchk(lnbp_pkg::ADDR_IRQ_STATUS, 8'h01, "shutdown event");
        chk1(irq, 1'b0, "irq masked");
        drive(1'b0, 16'h0000);
        // about one second, scaled like the short disable count
        cyc(OC * 1000 / 45);
        chk1(lnb_output_enable, 1'b0, "no restart");
        wr(lnbp_pkg::ADDR_IRQ_ENABLE, 8'h07);
        cyc(2);
        chk1(irq, 1'b1, "irq raised");
        wr(lnbp_pkg::ADDR_IRQ_CLEAR, 8'h01);
        cyc(2);
        chk1(irq, 1'b0, "irq cleared");
        rdchk(lnbp_pkg::ADDR_IRQ_CLEAR, 8'h00, "clear reads zero");
        wr(lnbp_pkg::ADDR_CTRL, 8'h01);
        cyc(1);
        chk1(lnb_output_enable, 1'b1, "re-enable");
        rdchk(lnbp_pkg::ADDR_STATUS, 8'h00, "fault flag cleared");
        wr(lnbp_pkg::ADDR_CTRL, 8'h03);
        drive(1'b1, 16'h0000);
        n = 0;
        while (limit_raise !== 1'b1 && n < 10) begin
            @(posedge clock);
            #1 n++;
        end
        m = 0;
        while (limit_raise === 1'b1 && m < 40) begin
            @(posedge clock);
            #1 m++;
        end
        chk8(8'(m), 8'(OC / 4), "raise length");
        drive(1'b0, 16'h0000);
        rdchk(lnbp_pkg::ADDR_CTRL, 8'h01, "boost bit self-clear");
        rdchk(lnbp_pkg::ADDR_IRQ_STATUS, 8'h04, "raise ended event");
        wr(lnbp_pkg::ADDR_IRQ_CLEAR, 8'h07);
        drive(1'b1, 16'h0000);
        seen = 1'b0;
        repeat (30) begin
            @(posedge clock);
            #1 seen = seen | limit_raise;
        end
        chk1(seen, 1'b0, "plain clamp");
        drive(1'b0, 16'h0000);
        cyc(2);
        chk1(lnb_output_enable, 1'b1, "short below limit time");
        // cable test runs with the sink off
        wr(lnbp_pkg::ADDR_CTRL, 8'h05);
        cyc(1);
        chk1(sink_current_disable, 1'b1, "sink off");
        drive(1'b0, 16'h5dc0);
        cyc(600);
        rdchk(lnbp_pkg::ADDR_STATUS, 8'h02, "cable open");
        chk1(irq, 1'b1, "cable irq");
        drive(1'b0, 16'h6f54);
        cyc(120);
        chk1(pulse_skip, 1'b1, "skip entry");
        drive(1'b0, 16'h6c98);
        cyc(40);
        chk1(pulse_skip, 1'b1, "skip hysteresis");
        drive(1'b0, 16'h6978);
        cyc(40);
        chk1(pulse_skip, 1'b0, "skip exit");
        drive(1'b0, 16'h0000);
        cyc(600);
        rdchk(lnbp_pkg::ADDR_STATUS, 8'h00, "cable flag live");
        wr(lnbp_pkg::ADDR_CTRL, 8'h01);
        @(posedge clock);
        tone_gate_input <= 1'b1;
        cyc(2);
        chk1(tone_active, 1'b1, "internal tone on");
        chk1(pulldown_strong, 1'b1, "strong pull-down");
        for (int pass = 0; pass < 2; pass++) begin
            lv = tone_level;
            n = 0;
            while (tone_level === lv && n < 600) begin
                @(posedge clock);
                #1 n++;
            end
        end
        chk1(n == 454, 1'b1, "tone half period");
        @(posedge clock);
        tone_gate_input <= 1'b0;
        cyc(2);
        chk1(tone_active, 1'b0, "internal tone gated");
        chk1(pulldown_strong, 1'b0, "weak pull-down");
        wr(lnbp_pkg::ADDR_CTRL, 8'h09);
        bad = 0;
        for (int i = 0; i < 1400; i++) begin
            @(posedge clock);
            g = tone_gate_input;
            tone_gate_input <= ((i / 227) % 2) == 1;
            #1 bad += (tone_level !== g);
        end
        chk1(bad == 0, 1'b1, "external tone copy");
        cyc(700);
        chk1(tone_active, 1'b1, "idle below 42 us");
        cyc(120);
        chk1(tone_active, 1'b0, "idle past 42 us");
        final_report();
    end
endmodule // lnbp_ctrl_tb
`default_nettype wire
